// *** rtl/sfrb_top.sv ***
// Purpose: special function register bank with reset-source dependent reset values
// Assumes: APB slave, 8-bit registers in the low byte of each word
// Notes: other reset types arrive as one-cycle requests from the reset controller
// Functional notes
// R1: software never touches unassigned addresses; such accesses get pslverr and read zero.
// R2: on full reset, mode register 0 loads 00h or 03h from boot pin.
// R3: partial resets keep the two mode select bits of mode register 0.
// R4: oscillator stop reset keeps bits 0,1,7 of oscillation stop register.
// R5: reset source register shows reset type; hardware reset gives XX00 001Xb.
// R6: full resets load pull-up register 1 with 00h or 02h from boot pin.
// R7: partial resets load pull-up register 1 from mode bits: 00b gives 00h, else 02h; the code decodes mode bit 0 only, so 10b also gives 00h.
// R8: count source protection resets to 00h, or 80h when protection initial bit 0.
// R9: hardware reset gives detector flags 08h and detector enable 00h.
// R10: software waits 100 us after re-enabling detector 0.
// R11: software waits 100 us after re-enabling detector 1.
// R12: detector 0 raises its reset request well within 200 us.
// R13: detector 1 raises its reset request well within 200 us.
// R14: detector 1 level from a 4-bit field; detector 0 level from option bit.
// R15: undefined reset bits must be written by software before use.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
module sfrb_top
  import sfrb_pkg::*;
#(
  parameter int EN_WAIT_CYC = SFRB_EN_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SFRB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_mode_pin,
  input wire sfrb_rst_req_s rst_req,
  input wire logic protection_initial_bit,
  input wire logic detector0_level_select,
  input wire logic det0_below,
  input wire logic det1_below,
  output logic vm0_reset_req,
  output logic vm1_reset_req,
  output logic [3:0] detector1_level_field,
  output logic detector0_level,
  output logic [1:0] mode_select
);
  generate
    if (SFRB_TRIP_LAT + 1 > SFRB_RESP_CYC) begin : g_chk
      $error("sfrb_top: trip latency exceeds response time");
    end
  endgenerate

  // boot pin synchroniser
  logic boot_s1, boot_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_s1 <= 1'b0;
      boot_s <= 1'b0;
    end else begin
      boot_s1 <= boot_mode_pin;
      boot_s <= boot_s1;
    end
  end

  // start-up sequence: wait for the synchroniser, then apply hardware reset values
  sfrb_state_e state, next_state;
  logic [1:0] wait_cnt, next_wait_cnt;

  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    case (state)
      ST_SYNC: begin
        next_wait_cnt = wait_cnt + 2'h1;
        if (wait_cnt == 2'h2) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_SYNC;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SYNC;
      wait_cnt <= 2'h0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // reset load request: start-up load or a reset from the controller
  logic apply;
  sfrb_rst_e kind;
  logic full_rst;

  always_comb begin
    apply = 1'b0;
    kind = RST_HW;
    if (state == ST_LOAD) begin
      apply = 1'b1;
    end else if (state == ST_RUN && rst_req.valid) begin
      apply = 1'b1;
      kind = rst_req.kind;
    end
    full_rst = (kind == RST_HW) || (kind == RST_POR) || (kind == RST_VM0);
  end

  // address decode
  logic hit;
  logic [5:0] slot;

  always_comb begin
    hit = 1'b0;
    slot = 6'h00;
    for (int i = 0; i < SFRB_NREG; i++) begin
      if (paddr[1:0] == 2'b00 && paddr[SFRB_AW-1:2] == SFRB_OFFS[i]) begin
        hit = 1'b1;
        slot = 6'(i);
      end
    end
  end

  // APB slave: one wait state, answer in the second access cycle
  logic access, wr_fire;
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;
  sfrb_byte_t regs [SFRB_NREG];
  sfrb_byte_t next_regs [SFRB_NREG];

  always_comb begin
    access = psel && penable;
    wr_fire = access && pready && pwrite && hit;
    next_pready = access && !pready && (state == ST_RUN);
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (next_pready) begin
      next_pslverr = !hit; // see R1
      if (hit && !pwrite) begin
        next_prdata = {24'h00_0000, regs[slot]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // detector channels
  logic det0_armed, det1_armed, det0_above, det1_above, det0_trip, det1_trip;

  sfrb_vdet #(
    .WAIT_CYC(EN_WAIT_CYC)
  ) u_det0 (
    .clk(clk),
    .rst_n(rst_n),
    .enable(regs[SL_VOLTAGE_DETECTOR_ENABLE][VOLTAGE_DETECTOR_ENABLE_DET0_EN]),
    .below(det0_below),
    .armed(det0_armed),
    .above(det0_above),
    .trip(det0_trip)
  );

  sfrb_vdet #(
    .WAIT_CYC(EN_WAIT_CYC)
  ) u_det1 (
    .clk(clk),
    .rst_n(rst_n),
    .enable(regs[SL_VOLTAGE_DETECTOR_ENABLE][VOLTAGE_DETECTOR_ENABLE_DET1_EN]),
    .below(det1_below),
    .armed(det1_armed),
    .above(det1_above),
    .trip(det1_trip)
  );

  // register file next values
  sfrb_byte_t src;

  always_comb begin
    next_regs = regs;
    src = 8'h00;
    if (apply) begin
      for (int i = 0; i < SFRB_NREG; i++) begin
        next_regs[i] = SFRB_RST[i];
      end
      if (full_rst) begin
        next_regs[SL_PM0] = boot_s ? PM0_BOOT_HI : 8'h00; // see R2
        next_regs[SL_PULLUP_CONTROL_1] = boot_s ? PULLUP_CONTROL_1_EXP : 8'h00; // see R6
      end else begin
        next_regs[SL_PM0][1:0] = regs[SL_PM0][1:0]; // see R3
        next_regs[SL_PULLUP_CONTROL_1] = regs[SL_PM0][0] ? PULLUP_CONTROL_1_EXP : 8'h00; // see R7
      end
      if (kind == RST_OSC) begin
        next_regs[SL_CM2] = (SFRB_RST[SL_CM2] & ~CM2_KEEP) | (regs[SL_CM2] & CM2_KEEP); // see R4
      end
      next_regs[SL_COUNT_SOURCE_PROTECTION_MODE] = protection_initial_bit ? 8'h00 : COUNT_SOURCE_PROTECTION_MODE_PROT; // see R8
      // detectors keep running through software-style resets
      if (kind == RST_SW || kind == RST_WDT || kind == RST_OSC) begin
        next_regs[SL_VOLTAGE_DETECTOR_ENABLE] = regs[SL_VOLTAGE_DETECTOR_ENABLE];
      end else begin
        next_regs[SL_VOLTAGE_DETECTOR_ENABLE] = SFRB_RST[SL_VOLTAGE_DETECTOR_ENABLE]; // see R9
      end
      // reset source flags: POR and VM0 share the cold flag, VM1 and VM2 share the VM flag
      src = RESET_SOURCE_DETERMINE_HW_VAL; // see R5
      case (kind)
        RST_HW: src[RESET_SOURCE_DETERMINE_COLD] = regs[SL_RESET_SOURCE_DETERMINE][RESET_SOURCE_DETERMINE_COLD];
        RST_POR, RST_VM0: src = 8'h01 << RESET_SOURCE_DETERMINE_COLD;
        RST_SW: src = 8'h01 << RESET_SOURCE_DETERMINE_SW;
        RST_WDT: src = 8'h01 << RESET_SOURCE_DETERMINE_WDT;
        RST_OSC: src = 8'h01 << RESET_SOURCE_DETERMINE_OSC;
        RST_VM1, RST_VM2: src = 8'h01 << RESET_SOURCE_DETERMINE_VM;
        default: src = RESET_SOURCE_DETERMINE_HW_VAL;
      endcase
      next_regs[SL_RESET_SOURCE_DETERMINE] = src;
    end else if (wr_fire) begin
      next_regs[slot] = pwdata[7:0];
    end
    // live detector 1 level flag, not writable
    next_regs[SL_VOLTAGE_DETECTOR_FLAGS][VOLTAGE_DETECTOR_FLAGS_DET1_ABOVE] = apply ? SFRB_RST[SL_VOLTAGE_DETECTOR_FLAGS][VOLTAGE_DETECTOR_FLAGS_DET1_ABOVE] : det1_above; // see R9
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SFRB_NREG; i++) begin
        regs[i] <= SFRB_RST[i]; // see R15
      end
    end else begin
      regs <= next_regs;
    end
  end

  // outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vm0_reset_req <= 1'b0;
      vm1_reset_req <= 1'b0;
      detector1_level_field <= 4'h0;
      detector0_level <= 1'b0;
      mode_select <= 2'b00;
    end else begin
      vm0_reset_req <= det0_trip; // see R12
      vm1_reset_req <= det1_trip; // see R13
      detector1_level_field <= regs[SL_LVL][3:0]; // see R14
      detector0_level <= detector0_level_select; // see R14
      mode_select <= regs[SL_PM0][1:0];
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_PM0_BOOT: assert property ( // see R2
    apply && full_rst |=> regs[SL_PM0] == ($past(boot_s) ? PM0_BOOT_HI : 8'h00))
    else $error("mode register 0 not loaded from boot pin");

  AST_PM0_KEEP: assert property ( // see R3
    apply && !full_rst |=> $stable(regs[SL_PM0][1:0]))
    else $error("partial reset changed mode select bits");

  AST_CM2_KEEP: assert property ( // see R4
    apply && kind == RST_OSC |=> (regs[SL_CM2] & CM2_KEEP) == ($past(regs[SL_CM2]) & CM2_KEEP))
    else $error("oscillator stop reset changed kept bits");

  AST_RESET_SOURCE_DETERMINE_HW: assert property ( // see R5
    apply && kind == RST_HW |=> regs[SL_RESET_SOURCE_DETERMINE][5:1] == 5'b00001)
    else $error("reset source wrong after hardware reset");

  AST_PULLUP_CONTROL_1_BOOT: assert property ( // see R6
    apply && full_rst |=> regs[SL_PULLUP_CONTROL_1] == ($past(boot_s) ? PULLUP_CONTROL_1_EXP : 8'h00))
    else $error("pull-up register 1 wrong after full reset");

  AST_PULLUP_CONTROL_1_MODE: assert property ( // see R7
    apply && !full_rst |=> regs[SL_PULLUP_CONTROL_1][1] == $past(regs[SL_PM0][0]) && regs[SL_PULLUP_CONTROL_1][0] == 1'b0)
    else $error("pull-up register 1 wrong after partial reset");

  AST_COUNT_SOURCE_PROTECTION_MODE: assert property ( // see R8
    apply |=> regs[SL_COUNT_SOURCE_PROTECTION_MODE] == ($past(protection_initial_bit) ? 8'h00 : COUNT_SOURCE_PROTECTION_MODE_PROT))
    else $error("count source protection reset value wrong");

  AST_VDET_HW: assert property ( // see R9
    apply && kind == RST_HW |=> regs[SL_VOLTAGE_DETECTOR_ENABLE] == 8'h00 && regs[SL_VOLTAGE_DETECTOR_FLAGS] == 8'h08)
    else $error("detector registers wrong after hardware reset");

  AST_VM0_RESP: assert property ( // see R12
    (det0_armed && regs[SL_VOLTAGE_DETECTOR_ENABLE][VOLTAGE_DETECTOR_ENABLE_DET0_EN] && det0_below)[*4] |=> vm0_reset_req)
    else $error("detector 0 reset request late");

  AST_VM1_RESP: assert property ( // see R13
    (det1_armed && regs[SL_VOLTAGE_DETECTOR_ENABLE][VOLTAGE_DETECTOR_ENABLE_DET1_EN] && det1_below)[*4] |=> vm1_reset_req)
    else $error("detector 1 reset request late");

  AST_LVL: assert property ( // see R14
    ##1 detector1_level_field == $past(regs[SL_LVL][3:0]))
    else $error("detector 1 level output stale");

  AST_UNMAPPED: assert property ( // see R1
    access && pready |-> pslverr == !hit && (hit || prdata == 32'h0000_0000))
    else $error("unmapped access answered wrongly");
endmodule

// *** rtl/sfrb_pkg.sv ***
// Purpose: shared constants and types of the special function register bank
// Assumes: 8-bit registers, one per aligned 32-bit APB word at four times the index
// Notes: bits that power up undefined are given zero here
package sfrb_pkg;
  localparam int SFRB_NREG = 49;
  localparam int SFRB_AW = 12;
  typedef logic [9:0] sfrb_idx_t;
  typedef logic [7:0] sfrb_byte_t;

  // register indices, in slot order
  localparam sfrb_idx_t SFRB_OFFS [SFRB_NREG] = '{
    10'h004, 10'h005, 10'h006, 10'h007, 10'h008, 10'h009, 10'h00A, 10'h00B,
    10'h00C, 10'h010, 10'h011, 10'h012, 10'h015, 10'h016, 10'h018, 10'h019,
    10'h01A, 10'h01B, 10'h01C, 10'h01E, 10'h300, 10'h308, 10'h309, 10'h30A,
    10'h30B, 10'h30E, 10'h318, 10'h31B, 10'h31C, 10'h31D, 10'h320, 10'h322,
    10'h323, 10'h324, 10'h360, 10'h361, 10'h362, 10'h363, 10'h366, 10'h369,
    10'h370, 10'h372, 10'h373, 10'h374, 10'h375, 10'h376, 10'h37C, 10'h37D,
    10'h3F0};
  localparam sfrb_byte_t SFRB_RST [SFRB_NREG] = '{
    8'h00, 8'h08, 8'h48, 8'h20, 8'h01, 8'h00, 8'h00, 8'h00,
    8'h02, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h02, 8'h08,
    8'h00, 8'h00, 8'h12, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};

  // slots with special reset handling, plus the detector 1 level slot
  localparam int SL_PM0 = 0;
  localparam int SL_CM2 = 8;
  localparam int SL_RESET_SOURCE_DETERMINE = 14;
  localparam int SL_VOLTAGE_DETECTOR_FLAGS = 15;
  localparam int SL_VOLTAGE_DETECTOR_ENABLE = 16;
  localparam int SL_PULLUP_CONTROL_1 = 35;
  localparam int SL_COUNT_SOURCE_PROTECTION_MODE = 46;
  localparam int SL_LVL = 48;

  // field values and positions
  localparam sfrb_byte_t PM0_BOOT_HI = 8'h03;
  localparam sfrb_byte_t PULLUP_CONTROL_1_EXP = 8'h02;
  localparam sfrb_byte_t CM2_KEEP = 8'h83;
  localparam sfrb_byte_t COUNT_SOURCE_PROTECTION_MODE_PROT = 8'h80;
  localparam sfrb_byte_t RESET_SOURCE_DETERMINE_HW_VAL = 8'h02;
  localparam int VOLTAGE_DETECTOR_FLAGS_DET1_ABOVE = 3;
  localparam int VOLTAGE_DETECTOR_ENABLE_DET0_EN = 5;
  localparam int VOLTAGE_DETECTOR_ENABLE_DET1_EN = 6;
  localparam int RESET_SOURCE_DETERMINE_COLD = 0;
  localparam int RESET_SOURCE_DETERMINE_HW = 1;
  localparam int RESET_SOURCE_DETERMINE_SW = 2;
  localparam int RESET_SOURCE_DETERMINE_WDT = 3;
  localparam int RESET_SOURCE_DETERMINE_OSC = 4;
  localparam int RESET_SOURCE_DETERMINE_VM = 5;

  // timing
  localparam int SFRB_CLK_MHZ = 40;
  localparam int SFRB_EN_WAIT_US = 100;
  localparam int SFRB_RESP_US = 200;
  localparam int SFRB_EN_WAIT_CYC = SFRB_EN_WAIT_US * SFRB_CLK_MHZ;
  localparam int SFRB_RESP_CYC = SFRB_RESP_US * SFRB_CLK_MHZ;
  localparam int SFRB_TRIP_LAT = 3;

  typedef enum logic [2:0] {
    RST_HW = 3'h0, RST_POR = 3'h1, RST_VM0 = 3'h2, RST_SW = 3'h3,
    RST_WDT = 3'h4, RST_OSC = 3'h5, RST_VM1 = 3'h6, RST_VM2 = 3'h7
  } sfrb_rst_e;

  typedef struct packed {
    logic valid;
    sfrb_rst_e kind;
  } sfrb_rst_req_s;

  typedef enum logic [1:0] {
    ST_SYNC = 2'b00, ST_LOAD = 2'b01, ST_RUN = 2'b11
  } sfrb_state_e;
endpackage

// *** rtl/sfrb_vdet.sv ***
// Purpose: one voltage detector channel: arming delay and reset request
// Assumes: below is an asynchronous comparator level, high under the threshold
// Notes: the request is a level that holds while the supply stays low
`timescale 1ns/10ps
module sfrb_vdet
  import sfrb_pkg::*;
#(
  parameter int WAIT_CYC = SFRB_EN_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic below,
  output logic armed,
  output logic above,
  output logic trip
);
  generate
    if (WAIT_CYC < 1 || WAIT_CYC > 65535) begin : g_chk
      $error("sfrb_vdet: WAIT_CYC out of range");
    end
  endgenerate

  logic s1, s2;
  logic [15:0] cnt, next_cnt;
  logic next_armed, next_trip;

  always_comb begin
    next_cnt = cnt;
    next_armed = armed;
    // re-enabling restarts the settle time before the detector is trusted
    if (!enable) begin
      next_cnt = '0;
      next_armed = 1'b0;
    end else if (!armed) begin
      next_cnt = cnt + 16'h0001;
      next_armed = (next_cnt >= 16'(WAIT_CYC));
    end
    next_trip = enable && armed && s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      cnt <= '0;
      armed <= 1'b0;
      trip <= 1'b0;
      above <= 1'b1;
    end else begin
      s1 <= below;
      s2 <= s1;
      cnt <= next_cnt;
      armed <= next_armed;
      trip <= next_trip;
      above <= ~s2;
    end
  end
endmodule

// *** dv/sfrb_top_tb_top.sv ***
// Purpose: self-checking bench for the register bank: reset values per reset type, apb access, detectors
// Assumes: detector arming wait shortened to 8 cycles, 40 MHz clock
// Notes: random data from a fixed-seed xorshift; expectations come from bench functions
`timescale 1ns/10ps
module sfrb_top_tb_top
  import sfrb_pkg::*;
;
  localparam int WAITC = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic boot_mode_pin = 1'b0;
  sfrb_rst_req_s rst_req = '0;
  logic protection_initial_bit = 1'b1;
  logic detector0_level_select = 1'b0;
  logic det0_below = 1'b0;
  logic det1_below = 1'b0;
  logic vm0_reset_req;
  logic vm1_reset_req;
  logic [3:0] detector1_level_field;
  logic detector0_level;
  logic [1:0] mode_select;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'd73154;
  logic [7:0] wv [SFRB_NREG];

  sfrb_top #(.EN_WAIT_CYC(WAITC)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_mode_pin(boot_mode_pin), .rst_req(rst_req), .protection_initial_bit(protection_initial_bit),
    .detector0_level_select(detector0_level_select), .det0_below(det0_below), .det1_below(det1_below),
    .vm0_reset_req(vm0_reset_req), .vm1_reset_req(vm1_reset_req),
    .detector1_level_field(detector1_level_field), .detector0_level(detector0_level),
    .mode_select(mode_select));

  always #12.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [11:0] ba(input int i);
    return {SFRB_OFFS[i], 2'b00};
  endfunction

  function automatic logic [7:0] pullup_control_1_exp(input bit full, input logic b, input logic [1:0] m);
    if (full) return b ? PULLUP_CONTROL_1_EXP : 8'h00;
    return (m == 2'b01 || m == 2'b11) ? PULLUP_CONTROL_1_EXP : 8'h00;
  endfunction

  function automatic logic [7:0] src_exp(input int k);
    case (k)
      0: return 8'h02;
      3: return 8'h04;
      4: return 8'h08;
      5: return 8'h10;
      6, 7: return 8'h20;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd, output logic [7:0] rd,
                     output logic err);
    int n;
    logic [31:0] r;
    r = rnd();
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {r[31:8], wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 0, 1);
    if (!wr) chk("prdata_upper", prdata[31:8], 0);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    logic [7:0] rd;
    logic e;
    apb(1'b1, ba(i), d, rd, e);
  endtask

  task automatic rdc(input string nm, input int i, input logic [7:0] exp);
    logic [7:0] rd;
    logic e;
    apb(1'b0, ba(i), 8'h00, rd, e);
    chk(nm, rd, exp);
    chk("pslverr", e, 0);
  endtask

  task automatic hw_rst(input logic b, input logic p);
    logic [31:0] r;
    r = rnd();
    @(posedge clk);
    rst_n <= 1'b0;
    boot_mode_pin <= b;
    protection_initial_bit <= p;
    detector0_level_select <= r[0];
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("det0_level", detector0_level, r[0]);
    for (int i = 0; i < SFRB_NREG; i++) begin
      if (i == SL_PM0) rdc("pm0", i, b ? PM0_BOOT_HI : 8'h00);
      else if (i == SL_PULLUP_CONTROL_1) rdc("pullup_control_1", i, pullup_control_1_exp(1, b, 2'b00));
      else if (i == SL_COUNT_SOURCE_PROTECTION_MODE) rdc("count_source_protection_mode", i, p ? 8'h00 : COUNT_SOURCE_PROTECTION_MODE_PROT);
      else if (i == SL_RESET_SOURCE_DETERMINE) rdc("reset_source_determine", i, RESET_SOURCE_DETERMINE_HW_VAL);
      else if (i == SL_VOLTAGE_DETECTOR_FLAGS || i == SL_VOLTAGE_DETECTOR_ENABLE) rdc("vdet", i, SFRB_RST[i]);
      else rdc("reset_val", i, SFRB_RST[i]);
    end
    chk("mode_select", mode_select, b ? 2'b11 : 2'b00);
  endtask

  task automatic pulse_rst(input int k);
    @(posedge clk);
    rst_req <= '{valid: 1'b1, kind: sfrb_rst_e'(k)};
    @(posedge clk);
    rst_req <= '0;
  endtask

  initial begin
    logic [7:0] rd;
    logic e;
    logic [7:0] v;
    logic [1:0] m;
    int n0;
    int n1;
    hw_rst(1'b0, 1'b1);
    for (int i = 0; i < SFRB_NREG; i++) begin
      wv[i] = rnd();
      wr(i, wv[i]);
    end
    for (int i = 0; i < SFRB_NREG; i++) begin
      if (i == SL_VOLTAGE_DETECTOR_FLAGS) rdc("rw", i, wv[i] | 8'h08);
      else rdc("rw", i, wv[i]);
    end
    chk("det1_level", detector1_level_field, wv[SL_LVL][3:0]);
    chk("mode_select", mode_select, wv[SL_PM0][1:0]);
    apb(1'b1, 12'h000, 8'h5A, rd, e);
    chk("unmapped_wr_err", e, 1);
    apb(1'b0, 12'h000, 8'h00, rd, e);
    chk("unmapped_rd_err", e, 1);
    chk("unmapped_rd", rd, 0);
    apb(1'b0, 12'h011, 8'h00, rd, e);
    chk("misaligned_err", e, 1);
    hw_rst(1'b1, 1'b0);
    for (int j = 0; j < 16; j++) begin
      for (int k = 0; k < 8; k++) begin
        v = rnd();
        m = (j < 4) ? j[1:0] : v[1:0];
        wr(SL_PM0, {v[7:2], m});
        v = rnd();
        wr(SL_CM2, v);
        pulse_rst(k);
        if (k <= 2) begin
          rdc("pm0_full", SL_PM0, PM0_BOOT_HI);
          rdc("pullup_control_1_full", SL_PULLUP_CONTROL_1, pullup_control_1_exp(1, 1'b1, m));
        end else begin
          rdc("pm0_part", SL_PM0, {6'h00, m});
          rdc("pullup_control_1_part", SL_PULLUP_CONTROL_1, pullup_control_1_exp(0, 1'b1, m));
        end
        rdc("cm2", SL_CM2, (k == 5) ? ((v & CM2_KEEP) | (SFRB_RST[SL_CM2] & ~CM2_KEEP)) : 8'h02);
        apb(1'b0, ba(SL_RESET_SOURCE_DETERMINE), 8'h00, rd, e);
        chk("reset_source_determine", rd & 8'hFE, src_exp(k));
      end
    end
    det0_below <= 1'b1;
    det1_below <= 1'b1;
    repeat (20) @(posedge clk);
    chk("vm0_disabled", vm0_reset_req, 0);
    chk("vm1_disabled", vm1_reset_req, 0);
    det0_below <= 1'b0;
    det1_below <= 1'b0;
    wr(SL_VOLTAGE_DETECTOR_ENABLE, 8'h60);
    repeat (WAITC + 4) @(posedge clk);
    det0_below <= 1'b1;
    det1_below <= 1'b1;
    n0 = -1;
    n1 = -1;
    for (int c = 0; c < SFRB_RESP_CYC && (n0 < 0 || n1 < 0); c++) begin
      @(posedge clk);
      if (n0 < 0 && vm0_reset_req === 1'b1) n0 = c;
      if (n1 < 0 && vm1_reset_req === 1'b1) n1 = c;
    end
    chk("vm0_in_time", n0 >= 0, 1);
    chk("vm1_in_time", n1 >= 0, 1);
    det0_below <= 1'b0;
    det1_below <= 1'b0;
    repeat (10) @(posedge clk);
    end_sim();
  end

  initial begin
    #(25 * 40000);
    err_count++;
    end_sim();
  end
endmodule
